// ---- logic/bfx_pkg.sv ----
// Package of constants and carrier types for the bit field extract unit
// Functional notes
// - Sign-extending extract widens the selected second-source field to 32 bits.
// - Signed extract: shift left by left amount, then arithmetic right shift.
// - Left amount is 31 minus field msb; right amount adds field lsb.
// - Register form: right amount in first-source bits 0-4, left in 5-9.
// - Both extracts have constant and register forms, on either shift unit side.
// - Signed extract: signed source, unsigned five-bit constants, cross path source in register form.
// - Zero-extending extract fills bits above the field with zeros.
// - Zero-extending extract takes unsigned operands, cross path in register form.
// - Unsigned extract: left shift then logical right shift, same amounts.
// - Unsigned register form: bit 12 cross path, bits 11-6 101011, side, parallel.
// - Constant form: dst 27-23, source 22-18, left 17-13, right 12-8.
package bfx_pkg;
  localparam int          DATA_W        = 32;
  localparam int          AMT_W         = 5;
  localparam int          REG_W         = 5;
  localparam logic [1:0]  CST_HI_CODE   = 2'h1;
  localparam logic [3:0]  CST_LO_S_CODE = 4'h2;
  localparam logic [3:0]  CST_LO_U_CODE = 4'h0;
  localparam logic [5:0]  REG_OP_S_CODE = 6'h2f;
  localparam logic [5:0]  REG_OP_U_CODE = 6'h2b;
  localparam logic [3:0]  REG_LO_CODE   = 4'h8;
  localparam logic [2:0]  CREG_ALWAYS   = 3'h0;
  localparam logic [31:0] ZERO_WORD     = 32'h0000_0000;

  typedef struct packed {
    logic [2:0] creg;
    logic       z;
    logic [4:0] dst;
    logic [4:0] field_src;
    logic [4:0] f17_13;
    logic [4:0] f12_8;
    logic [1:0] f7_6;
    logic [3:0] f5_2;
    logic       side;
    logic       par;
  } bfx_instr_t;

  typedef struct packed {
    logic        valid;
    logic        side;
    logic [4:0]  dst;
    logic [31:0] data;
  } bfx_wb_t;
endpackage

// ---- logic/bfx_unit.sv ----
// Bit field extract datapath with decode, predication and one-cycle write-back
`timescale 1ns/1ps
module bfx_unit import bfx_pkg::*; (
  input  wire logic                  mclk_i,
  input  wire logic                  reset_i,
  input  wire logic                  issue_i,
  input  wire logic [31:0]           instr_i,
  input  wire logic [DATA_W-1:0]     second_source_i,
  input  wire logic [DATA_W-1:0]     first_source_i,
  input  wire logic [7:0]            cond_regs_i,
  output bfx_wb_t                    wb_o,
  output logic                       xpath_o,
  output logic                       parallel_o
);
  bfx_instr_t        ins;
  logic              cst_s;
  logic              cst_u;
  logic              reg_s;
  logic              reg_u;
  logic              is_ext;
  logic              signed_op;
  logic              pred_ok;
  logic              cval;
  logic [AMT_W-1:0]  left_amt;
  logic [AMT_W-1:0]  right_amt;
  logic [DATA_W-1:0] shl;
  logic [DATA_W-1:0] next_data;

  assign ins = bfx_instr_t'(instr_i);

  // Constant and register forms for both variants
  assign cst_s = (ins.f7_6 == CST_HI_CODE) && (ins.f5_2 == CST_LO_S_CODE);
  assign cst_u = (ins.f7_6 == 2'h0) && (ins.f5_2 == CST_LO_U_CODE);
  assign reg_s = ({ins.f12_8[3:0], ins.f7_6} == REG_OP_S_CODE) && (ins.f5_2 == REG_LO_CODE);
  assign reg_u = ({ins.f12_8[3:0], ins.f7_6} == REG_OP_U_CODE) && (ins.f5_2 == REG_LO_CODE);
  assign is_ext = cst_s | cst_u | reg_s | reg_u;
  assign signed_op = cst_s | reg_s;

  // Register form: upper 22 bits of first source not checked, result then undefined
  assign left_amt  = (reg_s | reg_u) ? first_source_i[9:5] : ins.f17_13;
  assign right_amt = (reg_s | reg_u) ? first_source_i[4:0] : ins.f12_8;

  // Predicate: register code selects a condition bit, z inverts the test
  always_comb begin
    unique case (ins.creg)
      3'h1: cval = cond_regs_i[1];
      3'h2: cval = cond_regs_i[2];
      3'h3: cval = cond_regs_i[3];
      3'h4: cval = cond_regs_i[4];
      3'h5: cval = cond_regs_i[5];
      3'h6: cval = cond_regs_i[6];
      3'h7: cval = cond_regs_i[7];
      CREG_ALWAYS: cval = 1'b1;
    endcase
  end
  assign pred_ok = (ins.creg == CREG_ALWAYS) ? ~ins.z : (ins.z ? ~cval : cval);

  assign shl = second_source_i << left_amt;
  always_comb begin
    if (signed_op) begin
      next_data = DATA_W'($signed(shl) >>> right_amt);
    end else begin
      next_data = shl >> right_amt;
    end
  end

  // Single-cycle result, no delay slots
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      wb_o <= '0;
    end else begin
      wb_o.valid <= issue_i && is_ext && pred_ok;
      wb_o.side  <= ins.side;
      wb_o.dst   <= ins.dst;
      wb_o.data  <= next_data;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      xpath_o    <= 1'b0;
      parallel_o <= 1'b0;
    end else begin
      xpath_o    <= issue_i && (reg_s | reg_u) && ins.f12_8[4];
      parallel_o <= issue_i && ins.par;
    end
  end

  // Write-back timing and predication
  AST_ONE_CYCLE: assert property (@(posedge mclk_i) disable iff (reset_i)
    issue_i && is_ext && pred_ok
    |=> wb_o.valid) else $error("extract result not written");

  AST_FALSE_PRED: assert property (@(posedge mclk_i) disable iff (reset_i)
    issue_i && !pred_ok
    |=> !wb_o.valid) else $error("false predicate wrote");

  AST_NO_ISSUE: assert property (@(posedge mclk_i) disable iff (reset_i)
    !issue_i
    |=> !wb_o.valid) else $error("write-back without issue");

  AST_NOT_EXT: assert property (@(posedge mclk_i) disable iff (reset_i)
    issue_i && !is_ext
    |=> !wb_o.valid) else $error("foreign opcode wrote");

  AST_Z_TRUE: assert property (@(posedge mclk_i) disable iff (reset_i)
    issue_i && is_ext && ins.creg != CREG_ALWAYS && ins.z && !cval
    |=> wb_o.valid) else $error("zero test predicate ignored");

  AST_NEVER: assert property (@(posedge mclk_i) disable iff (reset_i)
    issue_i && ins.creg == CREG_ALWAYS && ins.z
    |=> !wb_o.valid) else $error("never predicate wrote");

  // Reset clears every output at the next edge
  AST_RESET_CLEAR: assert property (@(posedge mclk_i)
    reset_i
    |=> !wb_o.valid && !xpath_o && !parallel_o) else $error("outputs not cleared by reset");

  // Decode
  AST_ONE_DECODE: assert property (@(posedge mclk_i) disable iff (reset_i)
    issue_i
    |-> $onehot0({cst_s, cst_u, reg_s, reg_u})) else $error("two extract forms decoded");

  AST_CST_AMT: assert property (@(posedge mclk_i) disable iff (reset_i)
    issue_i && (cst_s | cst_u)
    |-> left_amt == instr_i[17:13] && right_amt == instr_i[12:8]) else $error("constant amounts misrouted");

  AST_REG_SRC: assert property (@(posedge mclk_i) disable iff (reset_i)
    issue_i && (reg_s | reg_u)
    |-> left_amt == first_source_i[9:5] && right_amt == first_source_i[4:0]) else $error("register amounts misrouted");

  // Fill and field checks, constant form
  AST_ZERO_FILL: assert property (@(posedge mclk_i) disable iff (reset_i)
    issue_i && cst_u && ins.f12_8 != 5'h0
    |=> wb_o.data[31] == 1'b0) else $error("zero fill broken");

  AST_SIGN_FILL: assert property (@(posedge mclk_i) disable iff (reset_i)
    issue_i && cst_s && ins.f17_13 == 5'h0 && ins.f12_8 == 5'h1f
    |=> wb_o.data == {32{$past(second_source_i[31])}}) else $error("sign fill broken");

  AST_CST_FIELD: assert property (@(posedge mclk_i) disable iff (reset_i)
    issue_i && cst_u && ins.f17_13 == 5'h1f && ins.f12_8 == 5'h1f
    |=> wb_o.data == {31'h0, $past(second_source_i[0])}) else $error("constant field misread");

  AST_CST_U_IDENT: assert property (@(posedge mclk_i) disable iff (reset_i)
    issue_i && cst_u && ins.f17_13 == 5'h0 && ins.f12_8 == 5'h0
    |=> wb_o.data == $past(second_source_i)) else $error("unsigned zero shift altered data");

  AST_CST_S_IDENT: assert property (@(posedge mclk_i) disable iff (reset_i)
    issue_i && cst_s && ins.f17_13 == 5'h0 && ins.f12_8 == 5'h0
    |=> wb_o.data == $past(second_source_i)) else $error("signed zero shift altered data");

  AST_U_LOW_BYTE: assert property (@(posedge mclk_i) disable iff (reset_i)
    issue_i && cst_u && ins.f17_13 == 5'd24 && ins.f12_8 == 5'd24
    |=> wb_o.data == {24'h0, $past(second_source_i[7:0])}) else $error("unsigned low byte wrong");

  AST_S_LOW_BYTE: assert property (@(posedge mclk_i) disable iff (reset_i)
    issue_i && cst_s && ins.f17_13 == 5'd24 && ins.f12_8 == 5'd24
    |=> wb_o.data == {{24{$past(second_source_i[7])}}, $past(second_source_i[7:0])}) else $error("signed low byte wrong");

  AST_U_MID_BYTE: assert property (@(posedge mclk_i) disable iff (reset_i)
    issue_i && cst_u && ins.f17_13 == 5'd16 && ins.f12_8 == 5'd24
    |=> wb_o.data == {24'h0, $past(second_source_i[15:8])}) else $error("unsigned middle byte wrong");

  AST_S_MID_BYTE: assert property (@(posedge mclk_i) disable iff (reset_i)
    issue_i && cst_s && ins.f17_13 == 5'd16 && ins.f12_8 == 5'd24
    |=> wb_o.data == {{24{$past(second_source_i[15])}}, $past(second_source_i[15:8])}) else $error("signed middle byte wrong");

  AST_U_TOP_HALF: assert property (@(posedge mclk_i) disable iff (reset_i)
    issue_i && cst_u && ins.f17_13 == 5'h0 && ins.f12_8 == 5'd16
    |=> wb_o.data == {16'h0, $past(second_source_i[31:16])}) else $error("logical right shift wrong");

  // Fill and field checks, register form
  AST_REG_AMT: assert property (@(posedge mclk_i) disable iff (reset_i)
    issue_i && reg_u && first_source_i[9:0] == 10'h000
    |=> wb_o.data == $past(second_source_i)) else $error("register amounts misread");

  AST_REG_S_IDENT: assert property (@(posedge mclk_i) disable iff (reset_i)
    issue_i && reg_s && first_source_i[9:0] == 10'h000
    |=> wb_o.data == $past(second_source_i)) else $error("signed register zero shift altered data");

  AST_REG_BIT0: assert property (@(posedge mclk_i) disable iff (reset_i)
    issue_i && reg_u && first_source_i[9:0] == 10'h3ff
    |=> wb_o.data == {31'h0, $past(second_source_i[0])}) else $error("register bit zero field wrong");

  AST_REG_SIGN: assert property (@(posedge mclk_i) disable iff (reset_i)
    issue_i && reg_s && first_source_i[9:0] == 10'h01f
    |=> wb_o.data == {32{$past(second_source_i[31])}}) else $error("register sign fill broken");

  AST_REG_TOP_ZERO: assert property (@(posedge mclk_i) disable iff (reset_i)
    issue_i && reg_u && first_source_i[4:0] != 5'h0
    |=> wb_o.data[31] == 1'b0) else $error("register zero fill broken");

  AST_U_LOW_HALF: assert property (@(posedge mclk_i) disable iff (reset_i)
    issue_i && reg_u && first_source_i[9:0] == 10'h210
    |=> wb_o.data == {16'h0, $past(second_source_i[15:0])}) else $error("register unsigned half wrong");

  AST_S_LOW_HALF: assert property (@(posedge mclk_i) disable iff (reset_i)
    issue_i && reg_s && first_source_i[9:0] == 10'h210
    |=> wb_o.data == {{16{$past(second_source_i[15])}}, $past(second_source_i[15:0])}) else $error("register signed half wrong");

  // Side band outputs
  AST_XPATH: assert property (@(posedge mclk_i) disable iff (reset_i)
    issue_i && cst_s
    |=> !xpath_o) else $error("cross path on constant form");

  AST_XPATH_REG: assert property (@(posedge mclk_i) disable iff (reset_i)
    issue_i && (reg_s | reg_u)
    |=> xpath_o == $past(instr_i[12])) else $error("cross path bit not followed");

  AST_XPATH_IDLE: assert property (@(posedge mclk_i) disable iff (reset_i)
    !issue_i
    |=> !xpath_o) else $error("cross path without issue");

  AST_PAR_COPY: assert property (@(posedge mclk_i) disable iff (reset_i)
    issue_i
    |=> parallel_o == $past(instr_i[0])) else $error("parallel bit not copied");

  AST_PAR_IDLE: assert property (@(posedge mclk_i) disable iff (reset_i)
    !issue_i
    |=> !parallel_o) else $error("parallel flag without issue");

  AST_DST: assert property (@(posedge mclk_i) disable iff (reset_i)
    issue_i && is_ext
    |=> wb_o.dst == $past(instr_i[27:23]) && wb_o.side == $past(instr_i[1])) else $error("destination or side wrong");
endmodule

// ---- verif/bfx_rf_model.sv ----
// Register file model that feeds operands to the extract unit
`timescale 1ns/1ps
module bfx_rf_model (
  input  wire logic [31:0] instr_i,
  output logic [31:0]      first_source_o,
  output logic [31:0]      second_source_o
);
  logic [31:0] rf [32];
  task automatic load(input logic [4:0] idx, input logic [31:0] val);
    rf[idx] = val;
  endtask
  // Upper bits forced to zero, else result undefined
  assign first_source_o  = {22'h00_0000, rf[instr_i[17:13]][9:0]};
  assign second_source_o = rf[instr_i[22:18]];
endmodule

// ---- verif/bit_field_extract_unit_test.sv ----
// Self-checking bench for the bit field extract unit
`timescale 1ns/1ps
module bit_field_extract_unit_test;
  import bfx_pkg::*;
  logic        mclk_i = 1'b0, reset_i = 1'b1, issue_i = 1'b0, xpath_o, parallel_o;
  logic [31:0] instr_i = 32'h0000_0000, s1, s2;
  logic [7:0]  cond_regs_i = 8'h02;
  bfx_wb_t     wb_o;
  int          fail_count = 0, n_checks = 0, cyc = 0;
  always #12.5 mclk_i = ~mclk_i;
  bfx_rf_model u_rf (.instr_i(instr_i), .first_source_o(s1), .second_source_o(s2));
  bfx_unit u_dut (.mclk_i(mclk_i), .reset_i(reset_i), .issue_i(issue_i), .instr_i(instr_i),
    .second_source_i(s2), .first_source_i(s1), .cond_regs_i(cond_regs_i), .wb_o(wb_o),
    .xpath_o(xpath_o), .parallel_o(parallel_o));
  task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  function automatic logic [31:0] ref_x(logic [31:0] v, logic [4:0] l, logic [4:0] r, logic sg);
    logic [31:0] t;
    t = v << l;
    return sg ? 32'($signed(t) >>> r) : t >> r;
  endfunction
  // Issue one word, judge the write-back one cycle later
  task automatic op(input logic [31:0] w, input logic v, input logic [31:0] d);
    @(posedge mclk_i) #2;
    issue_i = 1'b1;
    instr_i = w;
    @(posedge mclk_i) #2;
    issue_i = 1'b0;
    chk({xpath_o, parallel_o, wb_o.valid, v ? {wb_o.dst, wb_o.data} : 37'h0},
        {w[12] & (w[5:2] == REG_LO_CODE), w[0], v, v ? {w[27:23], d} : 37'h0});
    chk({39'h0, v ? wb_o.side : 1'b0}, {39'h0, v ? w[1] : 1'b0});
  endtask
  task automatic t_forms();
    logic [31:0] w;
    op({9'h004, 5'h3, 5'd10, 5'd19, 8'h00}, 1'b1, 32'h0000_121F);
    op({9'h006, 5'h4, 5'h5, 1'b0, 6'h2b, 6'h20}, 1'b1, 32'h0000_036E);
    for (int i = 0; i < 8; i++) begin
      w = i[1] ? {9'h00A, 5'h4, 5'h5, i[2], i[0] ? REG_OP_S_CODE : REG_OP_U_CODE, REG_LO_CODE, i[2], 1'b1}
        : {9'h00A, 5'h3, 5'd10, 5'd19, i[0] ? 6'h12 : 6'h00, i[2], 1'b0};
      op(w, 1'b1, i[1] ? ref_x(32'h03B6_E7D5, 10, 22, i[0]) : ref_x(32'h07A4_3F2A, 10, 19, i[0]));
    end
    $display("forms test done");
  endtask
  // Field 15..8 of a negative byte, both fills
  task automatic t_pred();
    op({9'h044, 5'h6, 5'd16, 5'd24, 6'h12, 2'h0}, 1'b1, 32'hFFFF_FF80);
    op({9'h044, 5'h6, 5'd16, 5'd24, 6'h00, 2'h0}, 1'b1, 32'h0000_0080);
    op({9'h064, 5'h6, 5'd16, 5'd24, 6'h12, 2'h0}, 1'b0, 32'h0);
    op({9'h0A4, 5'h6, 5'd16, 5'd24, 6'h12, 2'h0}, 1'b1, 32'hFFFF_FF80);
    op({9'h024, 5'h6, 5'd16, 5'd24, 6'h12, 2'h0}, 1'b0, 32'h0);
    $display("predicate test done");
  endtask
  // Hang guard well above the 15 issued words
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 2000) begin
      fail_count++;
      final_report();
    end
  end
  initial begin
    u_rf.load(5'h3, 32'h07A4_3F2A);
    u_rf.load(5'h4, 32'h03B6_E7D5);
    u_rf.load(5'h5, 32'h0000_0156);
    u_rf.load(5'h6, 32'h1234_80FF);
    repeat (8) @(posedge mclk_i);
    #2 reset_i = 1'b0;
    t_forms();
    t_pred();
    final_report();
  end
endmodule
